// ==== verilog/flash_self_program_access.sv ====
// Purpose: self-programming sequencer and access control for on-chip flash
// Assumes: AXI4-Lite register access, one write and one read at a time
// Notes:   CPU is idled through cpu_idle while an operation runs
//
// Operation
// - CPU idled until byte program finishes
// - CPU idled until sector erase completes
// - select bit steers reads and programming
// - alternate sector erase clears 256 bytes
// - fixed 8-bit random code, never erased
// - random code read at 0A7F with bit set
// - third key must be 0A else abort
// - fourth key must be 09 else abort
// - fifth key must be 06 else abort

`timescale 1ns/1ps

module flash_self_program_access
	import flash_sp_pkg::*;
#(
	parameter int         MAIN_AW     = 13,
	parameter int         ALT_AW      = 9,
	parameter logic [7:0] RANDOM_CODE = 8'h5A // arbitrary per-chip value
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [BUS_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [BUS_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire pm_req_t           pm_req,
	output logic [7:0]             pm_rd_data,
	output logic                   pm_rd_ack,
	output logic                   cpu_idle
);

	// ****************************************
	// register bus write channel
	// ****************************************
	logic              aw_hold_reg;
	logic              w_hold_reg;
	logic [7:0]        aw_idx_reg;
	logic [7:0]        wdata_reg;
	logic              lane0_reg;
	logic              wr_fire;
	logic              wr_do;
	logic              wr_mapped;

	assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
	assign wr_fire       = aw_hold_reg && w_hold_reg;
	assign wr_do         = wr_fire && lane0_reg;

	// address and data are taken in either order, then answered together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			aw_idx_reg  <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_reg <= 1'b1;
			aw_idx_reg  <= s_axi_awaddr[9:2];
		end else if (wr_fire) begin
			aw_hold_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_reg <= 1'b0;
			wdata_reg  <= 8'h00;
			lane0_reg  <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata[7:0];
			lane0_reg  <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_hold_reg <= 1'b0;
		end
	end

	always_comb begin
		case (aw_idx_reg)
			IDX_ARRAY_SEL, IDX_KEY_FIRST, IDX_KEY_SECOND,
			IDX_KEY_THIRD, IDX_KEY_FOURTH, IDX_KEY_FIFTH,
			IDX_PAGE, IDX_OFFSET, IDX_WDATA,
			IDX_STATUS: wr_mapped = 1'b1;
			default:    wr_mapped = 1'b0;
		endcase
	end

	// write response, unmapped addresses answer with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// software registers
	// ****************************************
	logic [7:0] array_sel_reg;
	logic [7:0] page_reg;
	logic [7:0] offset_reg;
	logic [7:0] wdata_hold_reg;
	logic [7:0] key1_reg;
	logic [3:0] key2_reg;
	logic [3:0] key3_reg;
	logic [3:0] key4_reg;
	logic [3:0] key5_reg;
	logic       alt_array_bit;

	assign alt_array_bit = array_sel_reg[ALT_BIT_POS];

	// plain storage; only bit 0 of the select register exists
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			array_sel_reg  <= REG_RESET;
			page_reg       <= REG_RESET;
			offset_reg     <= REG_RESET;
			wdata_hold_reg <= REG_RESET;
			key1_reg       <= REG_RESET;
			key2_reg       <= 4'h0;
			key3_reg       <= 4'h0;
			key4_reg       <= 4'h0;
			key5_reg       <= 4'h0;
		end else if (wr_do) begin
			case (aw_idx_reg)
				IDX_ARRAY_SEL:  array_sel_reg  <= {7'h00, wdata_reg[0]};
				IDX_PAGE:       page_reg       <= wdata_reg;
				IDX_OFFSET:     offset_reg     <= wdata_reg;
				IDX_WDATA:      wdata_hold_reg <= wdata_reg;
				IDX_KEY_FIRST:  key1_reg       <= wdata_reg;
				IDX_KEY_SECOND: key2_reg       <= wdata_reg[3:0];
				IDX_KEY_THIRD:  key3_reg       <= wdata_reg[3:0];
				IDX_KEY_FOURTH: key4_reg       <= wdata_reg[3:0];
				IDX_KEY_FIFTH:  key5_reg       <= wdata_reg[3:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// key sequence checker
	// ****************************************
	seq_state_t state_reg;
	logic       key_wr;
	logic       key_ok;
	logic       seq_abort;
	logic [7:0] exp_idx;
	logic [3:0] exp_val;

	assign key_wr = wr_do && (aw_idx_reg >= IDX_KEY_FIRST)
		&& (aw_idx_reg <= IDX_KEY_FIFTH);

	// expected key for the current step
	always_comb begin
		exp_idx = IDX_KEY_SECOND;
		exp_val = KEY2_VAL;
		case (state_reg)
			ST_K3: begin
				exp_idx = IDX_KEY_THIRD;
				exp_val = KEY3_VAL;
			end
			ST_K4: begin
				exp_idx = IDX_KEY_FOURTH;
				exp_val = KEY4_VAL;
			end
			ST_K5: begin
				exp_idx = IDX_KEY_FIFTH;
				exp_val = KEY5_VAL;
			end
			default: ;
		endcase
	end

	always_comb begin
		if (state_reg == ST_IDLE) begin
			key_ok = (aw_idx_reg == IDX_KEY_FIRST)
				&& (wdata_reg == OP_PROGRAM || wdata_reg == OP_ERASE);
		end else begin
			key_ok = (aw_idx_reg == exp_idx)
				&& (wdata_reg[3:0] == exp_val);
		end
		seq_abort = key_wr && !key_ok && (state_reg <= ST_K5);
	end

	// ****************************************
	// operation sequencer
	// ****************************************
	logic       op_erase_reg;
	logic       op_alt_reg;
	logic [7:0] op_page_reg;
	logic [7:0] op_offset_reg;
	logic [7:0] op_data_reg;
	logic [7:0] step_cnt_reg;
	logic       tick;
	logic       op_done;
	logic [11:0] period;

	assign period  = (state_reg == ST_PROG) ? 12'(PROG_CYCLES)
		: 12'(STEP_CYCLES);
	// last byte of a 256-byte sector ends the erase
	assign op_done = tick && ((state_reg == ST_PROG)
		|| (state_reg == ST_ERASE
		&& step_cnt_reg == 8'(SECTOR_BYTES - 1)));

	op_timer #(
		.W       (12)
	) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (state_reg == ST_PROG || state_reg == ST_ERASE),
		.period  (period),
		.tick    (tick)
	);

	// keys in order, then the nop gap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE, ST_K2, ST_K3, ST_K4: begin
					if (seq_abort) begin
						state_reg <= ST_IDLE;
					end else if (key_wr) begin
						state_reg <= seq_state_t'(state_reg + 4'h1);
					end
				end
				ST_K5: begin
					if (seq_abort) begin
						state_reg <= ST_IDLE;
					end else if (key_wr) begin
						state_reg <= ST_NOP;
					end
				end
				ST_NOP: begin
					if (step_cnt_reg[3:0] == NOP_COUNT - 4'h1) begin
						state_reg <= op_erase_reg ? ST_ERASE : ST_PROG;
					end
				end
				ST_PROG, ST_ERASE: begin
					if (op_done) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// operands latched when the last key lands, so late writes do no harm
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_erase_reg  <= 1'b0;
			op_alt_reg    <= 1'b0;
			op_page_reg   <= 8'h00;
			op_offset_reg <= 8'h00;
			op_data_reg   <= 8'h00;
		end else if (key_wr && key_ok && state_reg == ST_IDLE) begin
			op_erase_reg  <= (wdata_reg == OP_ERASE);
		end else if (key_wr && key_ok && state_reg == ST_K5) begin
			op_alt_reg    <= alt_array_bit;
			op_page_reg   <= page_reg;
			op_offset_reg <= offset_reg;
			op_data_reg   <= wdata_hold_reg;
		end
	end

	// nop gap counter, then byte index during an erase
	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg <= ST_K5) begin
			step_cnt_reg <= 8'h00;
		end else if (state_reg == ST_NOP) begin
			step_cnt_reg <= (step_cnt_reg[3:0] == NOP_COUNT - 4'h1)
				? 8'h00 : step_cnt_reg + 8'h01;
		end else if (tick) begin
			step_cnt_reg <= step_cnt_reg + 8'h01;
		end
	end

	// CPU held idle while the array is busy
	assign cpu_idle = (state_reg == ST_PROG) || (state_reg == ST_ERASE);

	// ****************************************
	// status flags, set wins over clear
	// ****************************************
	logic done_reg;
	logic abort_reg;
	logic stat_clr;

	assign stat_clr = wr_do && (aw_idx_reg == IDX_STATUS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_reg  <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			done_reg  <= op_done
				|| (done_reg && !(stat_clr && wdata_reg[STAT_DONE_POS]));
			abort_reg <= seq_abort
				|| (abort_reg && !(stat_clr && wdata_reg[STAT_ABORT_POS]));
		end
	end

	// ****************************************
	// arrays and program-memory reads
	// ****************************************
	mem_wr_t    wr_port;
	logic [7:0] main_rdata;
	logic [7:0] alt_rdata;
	logic [1:0] rd_sel_reg;
	logic       rand_hit;

	// writes go to the array chosen at sequence end
	always_comb begin
		wr_port.en   = tick;
		wr_port.addr = {op_page_reg[4:0], op_offset_reg};
		wr_port.data = op_data_reg;
		if (state_reg == ST_ERASE) begin
			wr_port.addr = {op_page_reg[4:0], step_cnt_reg};
			wr_port.data = ERASED_BYTE;
		end
	end

	nvm_mem #(
		.AW      (MAIN_AW)
	) u_main (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (wr_port.en && !op_alt_reg),
		.waddr   (wr_port.addr[MAIN_AW-1:0]),
		.wdata   (wr_port.data),
		.re      (pm_req.valid && !alt_array_bit),
		.raddr   (pm_req.addr[MAIN_AW-1:0]),
		.rdata   (main_rdata)
	);

	nvm_mem #(
		.AW      (ALT_AW)
	) u_alt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (wr_port.en && op_alt_reg),
		.waddr   (wr_port.addr[ALT_AW-1:0]),
		.wdata   (wr_port.data),
		.re      (pm_req.valid && alt_array_bit),
		.raddr   (pm_req.addr[ALT_AW-1:0]),
		.rdata   (alt_rdata)
	);

	// random code sits at a fixed address of the alternate space
	assign rand_hit = alt_array_bit && (pm_req.addr == RANDOM_ADDR);

	// remember which source answers, read data follow one clock later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_sel_reg <= 2'h0;
			pm_rd_ack  <= 1'b0;
		end else begin
			pm_rd_ack <= pm_req.valid;
			if (pm_req.valid) begin
				rd_sel_reg <= {rand_hit, alt_array_bit};
			end
		end
	end

	// code is a constant, no erase path reaches it
	assign pm_rd_data = rd_sel_reg[1] ? RANDOM_CODE
		: (rd_sel_reg[0] ? alt_rdata : main_rdata);

	// ****************************************
	// register bus read channel
	// ****************************************
	logic [7:0] rd_val;
	logic       rd_mapped;

	always_comb begin
		rd_val    = 8'h00;
		rd_mapped = 1'b1;
		case (s_axi_araddr[9:2])
			IDX_ARRAY_SEL:  rd_val = array_sel_reg;
			IDX_PAGE:       rd_val = page_reg;
			IDX_OFFSET:     rd_val = offset_reg;
			IDX_WDATA:      rd_val = wdata_hold_reg;
			IDX_KEY_FIRST:  rd_val = key1_reg;
			IDX_KEY_SECOND: rd_val = {4'h0, key2_reg};
			IDX_KEY_THIRD:  rd_val = {4'h0, key3_reg};
			IDX_KEY_FOURTH: rd_val = {4'h0, key4_reg};
			IDX_KEY_FIFTH:  rd_val = {4'h0, key5_reg};
			IDX_STATUS:     rd_val = {state_reg, 1'b0, abort_reg,
				done_reg, cpu_idle};
			default:        rd_mapped = 1'b0;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	// one read in flight, data held until the master takes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_val};
			s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ==== pkg/flash_sp_pkg.sv ====
// Purpose: shared constants and types for the flash self-programming block
// Assumes: 10 MHz system clock, one CPU instruction per clock
// Notes:   register byte address is four times the register index

package flash_sp_pkg;

	// ****************************************
	// register map (index, byte address = 4 x index)
	// ****************************************
	localparam int          BUS_AW         = 10;
	localparam logic [7:0]  IDX_ARRAY_SEL  = 8'hA7;
	localparam logic [7:0]  IDX_KEY_FIRST  = 8'hF2;
	localparam logic [7:0]  IDX_KEY_SECOND = 8'hF3;
	localparam logic [7:0]  IDX_KEY_THIRD  = 8'hF4;
	localparam logic [7:0]  IDX_KEY_FOURTH = 8'hF5;
	localparam logic [7:0]  IDX_KEY_FIFTH  = 8'hF6;
	localparam logic [7:0]  IDX_PAGE       = 8'hF7;
	localparam logic [7:0]  IDX_OFFSET     = 8'hF8;
	localparam logic [7:0]  IDX_WDATA      = 8'hF9;
	localparam logic [7:0]  IDX_STATUS     = 8'hFA;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int          ALT_BIT_POS    = 0;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam int          STAT_BUSY_POS  = 0;
	localparam int          STAT_DONE_POS  = 1;
	localparam int          STAT_ABORT_POS = 2;
	localparam int          STAT_STATE_POS = 4;

	// ****************************************
	// key values and operation codes
	// ****************************************
	localparam logic [7:0]  OP_PROGRAM     = 8'h6E;
	localparam logic [7:0]  OP_ERASE       = 8'hE6;
	localparam logic [3:0]  KEY2_VAL       = 4'h5;
	localparam logic [3:0]  KEY3_VAL       = 4'hA;
	localparam logic [3:0]  KEY4_VAL       = 4'h9;
	localparam logic [3:0]  KEY5_VAL       = 4'h6;

	// ****************************************
	// arrays, random code address, timing
	// ****************************************
	localparam logic [15:0] RANDOM_ADDR    = 16'h0A7F;
	localparam int          SECTOR_BYTES   = 256;
	localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          PROG_TIME_NS   = 20000;
	localparam int          ERASE_STEP_NS  = 1000;
	localparam int          PROG_CYCLES    =
		(PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          STEP_CYCLES    =
		(ERASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  NOP_COUNT      = 4'h4;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_K2    = 4'b0001,
		ST_K3    = 4'b0010,
		ST_K4    = 4'b0011,
		ST_K5    = 4'b0100,
		ST_NOP   = 4'b0101,
		ST_PROG  = 4'b0110,
		ST_ERASE = 4'b0111
	} seq_state_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} pm_req_t;

	typedef struct packed {
		logic        en;
		logic [12:0] addr;
		logic [7:0]  data;
	} mem_wr_t;

endpackage

// ==== verilog/nvm_mem.sv ====
// Purpose: byte-wide array model with one write and one read port
// Assumes: read data appear one clock after the read strobe
// Notes:   contents are not reset, like a real array

`timescale 1ns/1ps

module nvm_mem #(
	parameter int AW = 13
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);

	logic [7:0] mem [0:(1<<AW)-1];

	// write port
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read port
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= 8'h00;
		end else if (re) begin
			rdata <= mem[raddr];
		end
	end

endmodule

// ==== verilog/op_timer.sv ====
// Purpose: divider giving one-cycle enable pulses while running
// Assumes: period is at least one cycle
// Notes:   restarts from zero whenever run drops

`timescale 1ns/1ps

module op_timer #(
	parameter int W = 12
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         run,
	input  wire logic [W-1:0] period,
	output logic              tick
);

	logic [W-1:0] cnt_reg;

	assign tick = run && (cnt_reg == period - 1'b1);

	// cycle counter, cleared when idle so each operation starts fresh
	always_ff @(posedge aclk) begin
		if (!aresetn || !run || tick) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

endmodule

// ==== dv/flash_sp_monitor.sv ====
// Purpose: port-level assertions for the flash self-programming block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every instance of the block at the foot of this file

`timescale 1ns/1ps

module flash_sp_monitor
	import flash_sp_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire pm_req_t     pm_req,
	input wire logic        pm_rd_ack,
	input wire logic        cpu_idle
);

	// ****************************************
	// busy stretch length
	// ****************************************
	logic [12:0] idle_cnt;

	// counts cycles of the current busy stretch, cleared when it ends
	always_ff @(posedge aclk) begin
		if (!aresetn)
			idle_cnt <= 13'h0000;
		else if (cpu_idle)
			idle_cnt <= idle_cnt + 13'h0001;
		else
			idle_cnt <= 13'h0000;
	end

	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ****************************************
	// assertions
	// ****************************************
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response not on time");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer not on time");
	a_ready_block: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken while response pending");
	a_rdata_upper: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_ack_follows: assert property (
		pm_req.valid |=> pm_rd_ack)
		else $error("memory read not answered");
	a_ack_no_req: assert property (
		!pm_req.valid |=> !pm_rd_ack)
		else $error("memory read answered without request");
	a_idle_long: assert property (
		$fell(cpu_idle) |-> idle_cnt >= PROG_CYCLES)
		else $error("cpu released too early");
	a_idle_bound: assert property (
		cpu_idle |-> idle_cnt < 13'h0BB8)
		else $error("cpu held idle too long");

endmodule

bind flash_self_program_access flash_sp_monitor mon (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.pm_req, .pm_rd_ack, .cpu_idle);

// ==== dv/testbench.sv ====
// Purpose: self-checking bench for the flash self-programming block
// Assumes: AXI4-Lite master tasks, fixed random seed
// Notes:   erase runs at full length, about 2600 cycles

`timescale 1ns/1ps

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp=%h got=%h", n, e, g); end end

module testbench
	import flash_sp_pkg::*;
;
	localparam logic [7:0] CODE = 8'hC3; // arbitrary per-chip value

	logic              aclk, aresetn;
	logic [BUS_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic              s_axi_rready, pm_rd_ack, cpu_idle;
	logic [7:0]        pm_rd_data, rd;
	pm_req_t           pm_req;
	int                errors, checked;

	flash_self_program_access #(.RANDOM_CODE(CODE)) uut (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pm_req, .pm_rd_data, .pm_rd_ack, .cpu_idle);

	// ****************************************
	// report and bus tasks
	// ****************************************
	task final_report;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task timeout(input string what);
		errors++;
		$display("unexpected %s exp=done got=hang", what);
		final_report();
	endtask

	// response ready comes a cycle late so the slave must hold it
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		if (n == 100) timeout("write");
	endtask

	task automatic rdr(input logic [7:0] idx);
		int n;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				rs = s_axi_rresp;
				rd = s_axi_rdata[7:0];
				s_axi_rready <= 1'b0;
				break;
			end
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		if (n == 100) timeout("read");
	endtask

	// program-memory read, answer sampled in its one-cycle window
	task automatic pmr(input logic [15:0] a);
		@(posedge aclk);
		pm_req <= '{valid: 1'b1, addr: a};
		@(posedge aclk);
		pm_req.valid <= 1'b0;
		@(posedge aclk);
		`CHK("pm ack", 1'b1, pm_rd_ack)
		rd = pm_rd_data;
	endtask

	// full flash operation; bad >= 0 spoils that key to force an abort
	task automatic op(input logic [7:0] code, pg, off, dat, input int bad);
		logic [7:0] keys [5];
		int n;
		int need;
		keys = '{code, 8'h05, 8'h0A, 8'h09, 8'h06};
		need = (code == OP_PROGRAM) ? PROG_CYCLES : SECTOR_BYTES * STEP_CYCLES;
		if (bad >= 0) keys[bad] = keys[bad] ^ 8'h01;
		wr(IDX_PAGE, pg);
		wr(IDX_OFFSET, off);
		wr(IDX_WDATA, dat);
		for (int i = 0; i < 5; i++) wr(8'(IDX_KEY_FIRST + i), keys[i]);
		for (n = 0; n < 20 && !cpu_idle; n++) @(posedge aclk);
		if (bad >= 0) begin
			`CHK("idle on bad key", 1'b0, cpu_idle)
		end else begin
			`CHK("idle start", 1'b1, cpu_idle)
			for (n = 0; n < 4000 && cpu_idle; n++) @(posedge aclk);
			if (n == 4000) timeout("operation");
			`CHK("busy length", need, n)
		end
		rdr(IDX_STATUS);
		`CHK("status", (bad >= 0) ? 8'h04 : 8'h02, rd)
		wr(IDX_STATUS, 8'h06);
	endtask

	// ****************************************
	// clock, watchdog and main sequence
	// ****************************************
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial begin
		repeat (60000) @(posedge aclk);
		timeout("run");
	end

	initial begin
		logic [7:0] pg, off, dat;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		pm_req = '0;
		errors = 0;
		checked = 0;
		void'($urandom(4886));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(IDX_ARRAY_SEL);
		`CHK("select reset", REG_RESET, rd)
		`CHK("read resp", RESP_OKAY, rs)
		for (int i = 8'hF2; i <= 8'hFA; i++) begin
			rdr(8'(i));
			`CHK("reset value", REG_RESET, rd)
		end
		wr(8'h10, 8'hFF);
		`CHK("unmapped write", RESP_SLVERR, rs)
		rdr(8'h10);
		`CHK("unmapped read", RESP_SLVERR, rs)
		`CHK("unmapped data", 8'h00, rd)
		// lane 0 strobe low: answered but nothing stored
		s_axi_wstrb <= 4'hE;
		wr(IDX_PAGE, 8'h5A);
		s_axi_wstrb <= 4'hF;
		`CHK("masked resp", RESP_OKAY, rs)
		rdr(IDX_PAGE);
		`CHK("masked write", 8'h00, rd)
		$display("test registers done");
		pg = 8'($urandom_range(0, 31));
		off = 8'($urandom);
		dat = 8'($urandom);
		op(OP_PROGRAM, pg, off, dat, -1);
		op(OP_PROGRAM, pg, off ^ 8'h80, ~dat, -1);
		pmr({3'b000, pg[4:0], off});
		`CHK("main byte", dat, rd)
		pmr({3'b000, pg[4:0], off ^ 8'h80});
		`CHK("second byte", ~dat, rd)
		$display("test main program done");
		for (int k = 0; k < 5; k++) op(OP_PROGRAM, pg, off, ~dat, k);
		pmr({3'b000, pg[4:0], off});
		`CHK("byte after abort", dat, rd)
		$display("test aborts done");
		wr(IDX_ARRAY_SEL, 8'h01);
		rdr(IDX_ARRAY_SEL);
		`CHK("select set", 8'h01, rd)
		pmr(RANDOM_ADDR);
		`CHK("random code", CODE, rd)
		op(OP_PROGRAM, 8'h01, off, dat, -1);
		pmr({7'h00, 1'b1, off});
		`CHK("alt byte", dat, rd)
		op(OP_ERASE, 8'h01, 8'h00, 8'h00, -1);
		wr(IDX_PAGE, 8'h00);
		rdr(IDX_PAGE);
		`CHK("page cleared", 8'h00, rd)
		pmr({7'h00, 1'b1, off});
		`CHK("erased byte", ERASED_BYTE, rd)
		pmr({7'h00, 1'b1, 8'h00});
		`CHK("erased low", ERASED_BYTE, rd)
		pmr({7'h00, 1'b1, 8'hFF});
		`CHK("erased high", ERASED_BYTE, rd)
		pmr(RANDOM_ADDR);
		`CHK("code after erase", CODE, rd)
		$display("test alternate array done");
		wr(IDX_ARRAY_SEL, 8'h00);
		pmr({3'b000, pg[4:0], off});
		`CHK("main after select", dat, rd)
		$display("test select return done");
		// mid-run reset must clear the select bit again
		wr(IDX_ARRAY_SEL, 8'h01);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(IDX_ARRAY_SEL);
		`CHK("select after reset", REG_RESET, rd)
		$display("test reset done");
		final_report();
	end

endmodule
